// ==== rapm_pkg.sv ====
// Constants for the receive AU/path monitor register bank.
// Assumes byte-wide registers reached over a plain address/strobe port.
package rapm_pkg;

  // Register offsets, byte addresses on the plain register port.
  localparam logic [7:0] PROT_K1_OFS     = 8'h22;
  localparam logic [7:0] PROT_K2_OFS     = 8'h23;
  localparam logic [7:0] RETIME_CFG_OFS  = 8'h51;
  localparam logic [7:0] HPT_CFG1_OFS    = 8'h80;
  localparam logic [7:0] EXP_LABEL_OFS   = 8'h82;
  localparam logic [7:0] RCV_LABEL_OFS   = 8'h83;
  localparam logic [7:0] RDI_BITS_OFS    = 8'h85;
  localparam logic [7:0] MSA_CFG_OFS     = 8'h90;
  localparam logic [7:0] NEG_CNT_LO_OFS  = 8'h91;
  localparam logic [7:0] NEG_CNT_HI_OFS  = 8'h92;
  localparam logic [7:0] POS_CNT_LO_OFS  = 8'h93;
  localparam logic [7:0] POS_CNT_HI_OFS  = 8'h94;
  localparam logic [7:0] PTR_STATUS_OFS  = 8'hc4;
  localparam logic [7:0] PATH_STATUS_OFS = 8'hc5;
  localparam logic [7:0] AIS_STATUS_OFS  = 8'hd0;

  // Field positions.
  localparam int MSA_SS_EN_BIT     = 0;
  localparam int MSA_AIS_FRC_BIT   = 1;
  localparam int MSA_AIS_EN_BIT    = 2;
  localparam int HPT_REI_MODE_BIT  = 1;
  localparam int HPT_B3_MODE_BIT   = 2;
  localparam int HPT_AIS_EN_BIT    = 3;
  localparam int HPT_AIS_FRC_BIT   = 4;
  localparam int HPT_J1_LEN_BIT    = 5;
  localparam int HPT_SLM_SEL_BIT   = 6;
  localparam int HPT_RDI_SEL_BIT   = 7;
  localparam int RETIME_DIS_BIT    = 3;
  localparam int LOP_ST_BIT        = 7;
  localparam int RDI_ST_BIT        = 3;
  localparam int SLM_ST_BIT        = 4;
  localparam int PATH_AIS_ST_BIT   = 4;
  localparam int MSA_AIS_ST_BIT    = 5;

  // Reset values and writable masks.
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] HPT_CFG1_MASK = 8'hfe;
  localparam logic [2:0] MSA_CFG_RESET = 3'h0;

  // Persistence counts, pointer size bits and path trace lengths.
  localparam logic [2:0] PERSIST_SHORT = 3'h3;
  localparam logic [2:0] PERSIST_LONG  = 3'h5;
  localparam logic [2:0] PERSIST_MAX   = 3'h7;
  localparam logic [1:0] SS_EXPECTED   = 2'h2;
  localparam logic [6:0] TRACE_LEN_16  = 7'h10;
  localparam logic [6:0] TRACE_LEN_64  = 7'h40;

  // Live justification counter width.
  localparam int JUST_CNT_W = 11;

endpackage : rapm_pkg

// ==== rapm_regs.sv ====
// Receive AU pointer and path monitor register bank with its alarm steering.
// Assumes line-side strobes and bytes come from logic on the same clock, so
// they are used without synchronisers; registers are byte wide.
//
// Summary of operation
// [RL1] K1 byte from the protection bus is readable, read only, resets to zero.
// [RL2] K2 byte from the protection bus is readable, read only, resets to zero.
// [RL3] Auto-alarm enable passes adaptation AIS to path termination on alarm condition.
// [RL4] Adaptation force bit sends AIS to path termination unconditionally.
// [RL5] With size check enabled, pointer SS bits other than 10 raise loss of pointer.
// [RL6] Eleven-bit counter counts every negative pointer justification; the code stops counting at 2047.
// [RL7] Writing the negative counter upper byte snapshots it and clears it.
// [RL8] Retiming-made decrements do not count while retiming is enabled.
// [RL9] Eleven-bit counter counts every positive pointer justification; the code stops counting at 2047.
// [RL10] Writing the positive counter upper byte snapshots it and clears it.
// [RL11] Retiming-made increments do not count while retiming is enabled.
// [RL12] Remote defect status updates after RDI bits agree 3 or 5 frames.
// [RL13] Label mismatch status updates after 3 or 5 mismatches with expected label.
// [RL14] Path trace length is 16 bytes, or 64 bytes when selected.
// [RL15] Path force bit sends AIS from path termination to path adaptation.
// [RL16] Path auto-alarm enable passes AIS to path adaptation on alarm condition.
// [RL17] B3 counter counts bit errors, or errored blocks in block mode.
// [RL18] Path REI counter counts bit errors, or block errors in block mode.
// [RL19] Received G1 RDI bits are readable at their own register.
// [RL20] After snapshot, live counter restarts from zero; buffer holds until next snapshot.
//
// The implementer's own choice: the address-and-strobe port.

`timescale 1ns/1ps

module rapm_regs #(
  parameter int CNT_W = rapm_pkg::JUST_CNT_W
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             prot_valid,
  input  wire logic [7:0]       protection_bus_first_aps_byte,
  input  wire logic [7:0]       protection_bus_second_aps_byte,
  input  wire logic             pointer_valid,
  input  wire logic [1:0]       pointer_size_bits,
  input  wire logic             neg_just_event,
  input  wire logic             neg_just_by_retime,
  input  wire logic             pos_just_event,
  input  wire logic             pos_just_by_retime,
  input  wire logic             frame_pulse,
  input  wire logic [2:0]       g1_rdi_bits,
  input  wire logic             label_valid,
  input  wire logic [7:0]       received_signal_label,
  input  wire logic             adaptation_alarm_condition,
  input  wire logic             path_alarm_condition,
  output logic                  adaptation_ais,
  output logic                  path_ais,
  output logic                  size_bit_loss_of_pointer,
  output logic                  path_remote_defect_status,
  output logic                  label_mismatch_status,
  output logic      [6:0]       path_trace_length,
  output logic                  path_parity_counter_mode,
  output logic                  path_remote_error_counter_mode
);

  // The counters sit in two bytes each, so wider than sixteen cannot be read.
  if (CNT_W < 9 || CNT_W > 16)
  begin : g_width_check
    $error("rapm_regs: CNT_W must lie between 9 and 16");
  end

  typedef struct packed {
    logic [7:0]       k1;
    logic [7:0]       k2;
    logic [2:0]       msa_cfg;
    logic [7:0]       hpt_cfg;
    logic             retime_dis;
    logic [7:0]       exp_label;
    logic [7:0]       rcv_label;
    logic [2:0]       rdi_bits;
    logic [2:0]       rdi_cnt;
    logic             rdi_st;
    logic             slm_last;
    logic [2:0]       slm_cnt;
    logic             slm_st;
    logic             lop;
    logic [CNT_W-1:0] neg_live;
    logic [CNT_W-1:0] neg_hold;
    logic [CNT_W-1:0] pos_live;
    logic [CNT_W-1:0] pos_hold;
    logic             adapt_ais;
    logic             path_ais;
    logic [6:0]       trace_len;
    logic [7:0]       rdata;
  } rapm_state_s;

  rapm_state_s state_r;
  rapm_state_s state_nxt;

  // Run length of equal observations, saturating so it never wraps back below
  // the persistence threshold during a long steady run.
  function automatic logic [2:0] rapm_run(input logic same, input logic [2:0] cnt);
    logic [2:0] res;
    res = 3'h1;
    if (same)
    begin
      res = (cnt == rapm_pkg::PERSIST_MAX) ? cnt : cnt + 3'h1;
    end
    return res;
  endfunction : rapm_run

  // Justification counter step. A snapshot clears the live count, but an event
  // in the same cycle is kept as the first count of the new interval.
  function automatic logic [CNT_W-1:0] rapm_jstep(input logic [CNT_W-1:0] live,
                                                  input logic             ev,
                                                  input logic             snap);
    logic [CNT_W-1:0] res;
    res = live;
    if (snap)
    begin
      res = '0;
    end
    if (ev && res != '1)
    begin
      res = res + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    return res;
  endfunction : rapm_jstep

  // Byte reads of a counter buffer, upper bits padded with zero.
  function automatic logic [7:0] rapm_hi(input logic [CNT_W-1:0] v);
    logic [15:0] wide;
    wide = 16'h0000;
    wide[CNT_W-1:0] = v;
    return wide[15:8];
  endfunction : rapm_hi

  logic       wr_msa;
  logic       wr_hpt;
  logic       wr_retime;
  logic       wr_exp;
  logic       snap_neg;
  logic       snap_pos;
  logic       neg_count;
  logic       pos_count;
  logic [2:0] rdi_need;
  logic [2:0] slm_need;
  logic       slm_mis;
  logic [2:0] rdi_run;
  logic [2:0] slm_run;

  // Write decode and event qualification.
  always_comb
  begin
    wr_msa    = reg_wr && reg_addr == rapm_pkg::MSA_CFG_OFS;
    wr_hpt    = reg_wr && reg_addr == rapm_pkg::HPT_CFG1_OFS;
    wr_retime = reg_wr && reg_addr == rapm_pkg::RETIME_CFG_OFS;
    wr_exp    = reg_wr && reg_addr == rapm_pkg::EXP_LABEL_OFS;
    snap_neg  = reg_wr && reg_addr == rapm_pkg::NEG_CNT_HI_OFS;             // [RL7]
    snap_pos  = reg_wr && reg_addr == rapm_pkg::POS_CNT_HI_OFS;             // [RL10]
    // Retiming-made adjustments are local, not line events, so they are masked while retiming is enabled.
    neg_count = neg_just_event && !(neg_just_by_retime && !state_r.retime_dis); // [RL8]
    pos_count = pos_just_event && !(pos_just_by_retime && !state_r.retime_dis); // [RL11]
    rdi_need  = state_r.hpt_cfg[rapm_pkg::HPT_RDI_SEL_BIT] ?
                rapm_pkg::PERSIST_LONG : rapm_pkg::PERSIST_SHORT;
    slm_need  = state_r.hpt_cfg[rapm_pkg::HPT_SLM_SEL_BIT] ?
                rapm_pkg::PERSIST_LONG : rapm_pkg::PERSIST_SHORT;
    slm_mis   = received_signal_label != state_r.exp_label;
    rdi_run   = rapm_run(g1_rdi_bits == state_r.rdi_bits, state_r.rdi_cnt);
    slm_run   = rapm_run(slm_mis == state_r.slm_last, state_r.slm_cnt);
  end

  // Next-state logic for the whole bank.
  always_comb
  begin
    state_nxt = state_r;
    // Protection bus capture.
    if (prot_valid)
    begin
      state_nxt.k1 = protection_bus_first_aps_byte;                         // [RL1]
      state_nxt.k2 = protection_bus_second_aps_byte;                        // [RL2]
    end
    if (wr_msa)
    begin
      state_nxt.msa_cfg = reg_wdata[2:0];
    end
    if (wr_hpt)
    begin
      state_nxt.hpt_cfg = reg_wdata & rapm_pkg::HPT_CFG1_MASK;
    end
    // Trace length sits in its own flop, so the output carries no decode after it.
    state_nxt.trace_len = state_nxt.hpt_cfg[rapm_pkg::HPT_J1_LEN_BIT] ?
                          rapm_pkg::TRACE_LEN_64 : rapm_pkg::TRACE_LEN_16;  // [RL14]
    if (wr_retime)
    begin
      state_nxt.retime_dis = reg_wdata[rapm_pkg::RETIME_DIS_BIT];
    end
    if (wr_exp)
    begin
      state_nxt.exp_label = reg_wdata;
    end
    // Pointer size bits are checked on each new pointer; disabling clears LOP.
    if (!state_r.msa_cfg[rapm_pkg::MSA_SS_EN_BIT])
    begin
      state_nxt.lop = 1'b0;
    end
    else if (pointer_valid)
    begin
      state_nxt.lop = pointer_size_bits != rapm_pkg::SS_EXPECTED;           // [RL5]
    end
    // Justification counters and their snapshot buffers.
    state_nxt.neg_live = rapm_jstep(state_r.neg_live, neg_count, snap_neg); // [RL6] [RL20]
    state_nxt.pos_live = rapm_jstep(state_r.pos_live, pos_count, snap_pos); // [RL9] [RL20]
    if (snap_neg)
    begin
      state_nxt.neg_hold = state_r.neg_live;                                // [RL7]
    end
    if (snap_pos)
    begin
      state_nxt.pos_hold = state_r.pos_live;                                // [RL10]
    end
    // RDI persistence: status follows only a value held for the selected run.
    if (frame_pulse)
    begin
      state_nxt.rdi_bits = g1_rdi_bits;                                     // [RL19]
      state_nxt.rdi_cnt  = rdi_run;
      if (rdi_run >= rdi_need)
      begin
        state_nxt.rdi_st = g1_rdi_bits[2];                                  // [RL12]
      end
    end
    // Label mismatch persistence, symmetric so the alarm also clears.
    if (label_valid)
    begin
      state_nxt.rcv_label = received_signal_label;
      state_nxt.slm_last  = slm_mis;
      state_nxt.slm_cnt   = slm_run;
      if (slm_run >= slm_need)
      begin
        state_nxt.slm_st = slm_mis;                                         // [RL13]
      end
    end
    // AIS steering: force wins, otherwise the enabled alarm logic decides.
    state_nxt.adapt_ais = state_r.msa_cfg[rapm_pkg::MSA_AIS_FRC_BIT] ||    // [RL4]
                          (state_r.msa_cfg[rapm_pkg::MSA_AIS_EN_BIT] &&
                           adaptation_alarm_condition);                     // [RL3]
    state_nxt.path_ais  = state_r.hpt_cfg[rapm_pkg::HPT_AIS_FRC_BIT] ||    // [RL15]
                          (state_r.hpt_cfg[rapm_pkg::HPT_AIS_EN_BIT] &&
                           path_alarm_condition);                           // [RL16]
    // Read data stands only in the cycle after the read strobe.
    state_nxt.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        rapm_pkg::PROT_K1_OFS:     state_nxt.rdata = state_r.k1;           // [RL1]
        rapm_pkg::PROT_K2_OFS:     state_nxt.rdata = state_r.k2;           // [RL2]
        rapm_pkg::RETIME_CFG_OFS:
          state_nxt.rdata[rapm_pkg::RETIME_DIS_BIT] = state_r.retime_dis;
        rapm_pkg::HPT_CFG1_OFS:    state_nxt.rdata = state_r.hpt_cfg;
        rapm_pkg::EXP_LABEL_OFS:   state_nxt.rdata = state_r.exp_label;
        rapm_pkg::RCV_LABEL_OFS:   state_nxt.rdata = state_r.rcv_label;
        rapm_pkg::RDI_BITS_OFS:    state_nxt.rdata = {5'h00, state_r.rdi_bits}; // [RL19]
        rapm_pkg::MSA_CFG_OFS:     state_nxt.rdata = {5'h00, state_r.msa_cfg};
        rapm_pkg::NEG_CNT_LO_OFS:  state_nxt.rdata = state_r.neg_hold[7:0];
        rapm_pkg::NEG_CNT_HI_OFS:  state_nxt.rdata = rapm_hi(state_r.neg_hold);
        rapm_pkg::POS_CNT_LO_OFS:  state_nxt.rdata = state_r.pos_hold[7:0];
        rapm_pkg::POS_CNT_HI_OFS:  state_nxt.rdata = rapm_hi(state_r.pos_hold);
        rapm_pkg::PTR_STATUS_OFS:
          state_nxt.rdata[rapm_pkg::LOP_ST_BIT] = state_r.lop;
        rapm_pkg::PATH_STATUS_OFS:
        begin
          state_nxt.rdata[rapm_pkg::RDI_ST_BIT] = state_r.rdi_st;
          state_nxt.rdata[rapm_pkg::SLM_ST_BIT] = state_r.slm_st;
        end
        rapm_pkg::AIS_STATUS_OFS:
        begin
          state_nxt.rdata[rapm_pkg::MSA_AIS_ST_BIT]  = state_r.adapt_ais;
          state_nxt.rdata[rapm_pkg::PATH_AIS_ST_BIT] = state_r.path_ais;
        end
        default:                   state_nxt.rdata = 8'h00;
      endcase
    end
  end

  // The single state register.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_r            <= '0;
      state_r.msa_cfg    <= rapm_pkg::MSA_CFG_RESET;
      state_r.hpt_cfg    <= rapm_pkg::CFG_RESET;
      state_r.exp_label  <= rapm_pkg::CFG_RESET;
      state_r.trace_len  <= rapm_pkg::TRACE_LEN_16;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // All outputs come straight from state flops.
  assign reg_rdata                      = state_r.rdata;
  assign adaptation_ais                 = state_r.adapt_ais;
  assign path_ais                       = state_r.path_ais;
  assign size_bit_loss_of_pointer       = state_r.lop;
  assign path_remote_defect_status      = state_r.rdi_st;
  assign label_mismatch_status          = state_r.slm_st;
  assign path_trace_length              = state_r.trace_len;                          // [RL14]
  assign path_parity_counter_mode       = state_r.hpt_cfg[rapm_pkg::HPT_B3_MODE_BIT];  // [RL17]
  assign path_remote_error_counter_mode = state_r.hpt_cfg[rapm_pkg::HPT_REI_MODE_BIT]; // [RL18]

  // Checks on the behaviour above.
  default clocking rapm_cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_k1_capture: assert property (prot_valid |=>                                // [RL1]
    state_r.k1 == $past(protection_bus_first_aps_byte))
    else $error("K1 capture did not follow the protection bus");

  a_k2_readback: assert property ((prot_valid ##1 reg_rd &&
    reg_addr == rapm_pkg::PROT_K2_OFS) |=> reg_rdata ==                         // [RL2]
    $past(protection_bus_second_aps_byte, 2))
    else $error("K2 read did not return the captured byte");

  a_adapt_auto: assert property ((state_r.msa_cfg[rapm_pkg::MSA_AIS_EN_BIT] &&  // [RL3]
    adaptation_alarm_condition && !wr_msa) |=> adaptation_ais)
    else $error("Enabled adaptation alarm did not raise AIS");

  a_adapt_force: assert property ((!state_r.msa_cfg[rapm_pkg::MSA_AIS_FRC_BIT] && // [RL4]
    !state_r.msa_cfg[rapm_pkg::MSA_AIS_EN_BIT]) |=> !adaptation_ais)
    else $error("Adaptation AIS raised without force or enable");

  a_size_check: assert property ((pointer_valid &&                              // [RL5]
    state_r.msa_cfg[rapm_pkg::MSA_SS_EN_BIT] && !wr_msa) |=>
    size_bit_loss_of_pointer == ($past(pointer_size_bits) != rapm_pkg::SS_EXPECTED))
    else $error("Size bit check gave the wrong pointer loss");

  a_neg_snapshot: assert property (snap_neg |=>                                 // [RL7]
    state_r.neg_hold == $past(state_r.neg_live) && state_r.neg_live <= 1)
    else $error("Negative snapshot did not capture and clear");

  a_neg_retime: assert property ((neg_just_event && neg_just_by_retime &&       // [RL8]
    !state_r.retime_dis && !snap_neg) |=> $stable(state_r.neg_live))
    else $error("Retiming decrement was counted");

  a_pos_count: assert property ((pos_count && !snap_pos &&                      // [RL9]
    state_r.pos_live != '1) |=> state_r.pos_live == $past(state_r.pos_live) + 1)
    else $error("Positive justification was not counted");

  a_pos_retime: assert property ((pos_just_event && pos_just_by_retime &&       // [RL11]
    !state_r.retime_dis && !snap_pos) |=> $stable(state_r.pos_live))
    else $error("Retiming increment was counted");

  a_pos_hold_keep: assert property (!snap_pos |=> $stable(state_r.pos_hold))    // [RL20]
    else $error("Positive buffer changed without a snapshot");

  a_rdi_persist: assert property ((frame_pulse && rdi_run < rdi_need) |=>       // [RL12]
    $stable(path_remote_defect_status))
    else $error("Remote defect status changed before persistence");

  a_slm_persist: assert property ((label_valid && slm_run < slm_need) |=>       // [RL13]
    $stable(label_mismatch_status))
    else $error("Label mismatch status changed before persistence");

  a_path_force: assert property (state_r.hpt_cfg[rapm_pkg::HPT_AIS_FRC_BIT] ##1 // [RL15]
    state_r.hpt_cfg[rapm_pkg::HPT_AIS_FRC_BIT] |-> path_ais)
    else $error("Forced path AIS not sent");

  c_neg_snapshot: cover property (neg_count ##[1:4] snap_neg);
  c_slm_raise: cover property (!label_mismatch_status ##1 label_mismatch_status);
  c_rdi_raise: cover property (!path_remote_defect_status ##1 path_remote_defect_status);
  c_lop_raise: cover property (pointer_valid ##1 size_bit_loss_of_pointer);

endmodule : rapm_regs

// ==== rapm_line_model.sv ====
// Line-side partner of the AU/path monitor bank: pulses protection, pointer,
// justification, frame and label events. Assumes it shares the bank's clock.
`timescale 1ns/1ps
module rapm_line_model (
  input  wire logic       clock,
  output logic            prot_valid,
  output logic [7:0]      protection_bus_first_aps_byte,
  output logic [7:0]      protection_bus_second_aps_byte,
  output logic            pointer_valid,
  output logic [1:0]      pointer_size_bits,
  output logic            neg_just_event,
  output logic            neg_just_by_retime,
  output logic            pos_just_event,
  output logic            pos_just_by_retime,
  output logic            frame_pulse,
  output logic [2:0]      g1_rdi_bits,
  output logic            label_valid,
  output logic [7:0]      received_signal_label
);
  // Idle lines; data outside a strobe carries the inverse of its last value.
  initial
  begin
    {prot_valid, pointer_valid, neg_just_event, pos_just_event} = 4'h0;
    {neg_just_by_retime, pos_just_by_retime, frame_pulse, label_valid} = 4'h0;
    {protection_bus_first_aps_byte, protection_bus_second_aps_byte} = 16'h0000;
    {pointer_size_bits, g1_rdi_bits, received_signal_label} = 13'h0000;
  end

  // Each event is one clock wide; the next call lets one edge pass first.
  task automatic send_prot(input logic [7:0] k1, input logic [7:0] k2);
    @(posedge clock);
    prot_valid <= 1'b1;
    protection_bus_first_aps_byte <= k1;
    protection_bus_second_aps_byte <= k2;
    @(posedge clock);
    prot_valid <= 1'b0;
    protection_bus_first_aps_byte <= ~k1;
    protection_bus_second_aps_byte <= ~k2;
  endtask : send_prot

  task automatic send_pointer(input logic [1:0] ss);
    @(posedge clock);
    pointer_valid <= 1'b1;
    pointer_size_bits <= ss;
    @(posedge clock);
    pointer_valid <= 1'b0;
    pointer_size_bits <= ~ss;
  endtask : send_pointer

  // The retiming qualifier is inverted between events so it only counts with one.
  task automatic send_just(input logic neg, input logic rt);
    @(posedge clock);
    neg_just_event <= neg;
    pos_just_event <= !neg;
    neg_just_by_retime <= rt;
    pos_just_by_retime <= rt;
    @(posedge clock);
    neg_just_event <= 1'b0;
    pos_just_event <= 1'b0;
    neg_just_by_retime <= !rt;
    pos_just_by_retime <= !rt;
  endtask : send_just

  task automatic send_frame(input logic [2:0] rdi);
    @(posedge clock);
    frame_pulse <= 1'b1;
    g1_rdi_bits <= rdi;
    @(posedge clock);
    frame_pulse <= 1'b0;
    g1_rdi_bits <= ~rdi;
  endtask : send_frame

  task automatic send_label(input logic [7:0] lbl);
    @(posedge clock);
    label_valid <= 1'b1;
    received_signal_label <= lbl;
    @(posedge clock);
    label_valid <= 1'b0;
    received_signal_label <= ~lbl;
  endtask : send_label
endmodule : rapm_line_model

// ==== tb_top.sv ====
// Self-checking bench for the AU/path monitor register bank.
// Assumes the line model drives all event inputs on the same clock.
`timescale 1ns/1ps
module tb_top;
  logic        clock, reset, reg_wr, reg_rd, adaptation_alarm_condition, path_alarm_condition;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, protection_bus_first_aps_byte;
  logic [7:0]  protection_bus_second_aps_byte, received_signal_label;
  logic [1:0]  pointer_size_bits;
  logic [2:0]  g1_rdi_bits;
  logic [6:0]  path_trace_length;
  logic        prot_valid, pointer_valid, neg_just_event, neg_just_by_retime;
  logic        pos_just_event, pos_just_by_retime, frame_pulse, label_valid;
  logic        adaptation_ais, path_ais, size_bit_loss_of_pointer, path_remote_defect_status;
  logic        label_mismatch_status, path_parity_counter_mode, path_remote_error_counter_mode;
  int          failures, checks;

  rapm_regs #(.CNT_W(rapm_pkg::JUST_CNT_W)) u_rapm_regs (.clock, .reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .prot_valid, .protection_bus_first_aps_byte,
    .protection_bus_second_aps_byte, .pointer_valid, .pointer_size_bits, .neg_just_event,
    .neg_just_by_retime, .pos_just_event, .pos_just_by_retime, .frame_pulse, .g1_rdi_bits,
    .label_valid, .received_signal_label, .adaptation_alarm_condition, .path_alarm_condition,
    .adaptation_ais, .path_ais, .size_bit_loss_of_pointer, .path_remote_defect_status,
    .label_mismatch_status, .path_trace_length, .path_parity_counter_mode,
    .path_remote_error_counter_mode);

  rapm_line_model u_line (.clock, .prot_valid, .protection_bus_first_aps_byte,
    .protection_bus_second_aps_byte, .pointer_valid, .pointer_size_bits, .neg_just_event,
    .neg_just_by_retime, .pos_just_event, .pos_just_by_retime, .frame_pulse, .g1_rdi_bits,
    .label_valid, .received_signal_label);

  // 125 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the read edge, so sample there.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check(16'(reg_rdata), 16'(exp));
  endtask : rd_chk

  // Outputs settle one cycle after the taking edge; two edges leave margin.
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  // A hang is cut short and counted as a mismatch.
  initial
  begin
    repeat (100000) @(posedge clock);
    failures++;
    finish_test();
  end

  initial
  begin
    logic [7:0] hi;
    logic [7:0] lo;
    reset = 1'b1;
    {reg_wr, reg_rd, adaptation_alarm_condition, path_alarm_condition} = 4'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rd_chk(8'h22, 8'h00);
    rd_chk(8'h23, 8'h00);
    rd_chk(8'h90, 8'h00);
    rd_chk(8'h80, 8'h00);
    check(16'(path_trace_length), 16'h0010);
    u_line.send_prot(8'ha5, 8'h3c);
    reg_write(8'h22, 8'hff);
    rd_chk(8'h22, 8'ha5);
    rd_chk(8'h23, 8'h3c);
    // Read K2 in the cycle right after a capture.
    fork
      u_line.send_prot(8'h5a, 8'hc3);
      begin
        @(posedge clock);
        rd_chk(8'h23, 8'hc3);
      end
    join
    rd_chk(8'h40, 8'h00);
    // Force and auto-enable for both alarm stages, adaptation first.
    for (int k = 0; k < 2; k++)
    begin
      lo = k ? 8'h80 : 8'h90;
      @(posedge clock);
      {adaptation_alarm_condition, path_alarm_condition} <= k ? 2'h1 : 2'h2;
      settle();
      check(16'(k ? path_ais : adaptation_ais), 16'h0000);
      reg_write(lo, k ? 8'h10 : 8'h02);
      settle();
      check(16'(k ? path_ais : adaptation_ais), 16'h0001);
      rd_chk(8'hd0, k ? 8'h10 : 8'h20);
      reg_write(lo, k ? 8'h08 : 8'h04);
      settle();
      check(16'(k ? path_ais : adaptation_ais), 16'h0001);
      @(posedge clock);
      {adaptation_alarm_condition, path_alarm_condition} <= 2'h0;
      settle();
      check(16'(k ? path_ais : adaptation_ais), 16'h0000);
      reg_write(lo, 8'h00);
    end
    reg_write(8'h80, 8'hff);
    rd_chk(8'h80, 8'hfe);
    check(16'(path_trace_length), 16'h0040);
    check(16'({path_parity_counter_mode, path_remote_error_counter_mode}), 16'h0003);
    reg_write(8'h80, 8'h00);
    settle();
    check(16'({path_parity_counter_mode, path_remote_error_counter_mode}), 16'h0000);
    check(16'(path_trace_length), 16'h0010);
    // Size bits matter only while the check is enabled.
    u_line.send_pointer(2'h1);
    settle();
    check(16'(size_bit_loss_of_pointer), 16'h0000);
    reg_write(8'h90, 8'h01);
    u_line.send_pointer(2'h1);
    settle();
    check(16'(size_bit_loss_of_pointer), 16'h0001);
    rd_chk(8'hc4, 8'h80);
    u_line.send_pointer(2'h2);
    settle();
    check(16'(size_bit_loss_of_pointer), 16'h0000);
    // Justification counters: 300 counted events reach past the low byte.
    for (int k = 0; k < 2; k++)
    begin
      lo = k ? 8'h93 : 8'h91;
      hi = k ? 8'h94 : 8'h92;
      reg_write(8'h51, 8'h00);
      repeat (300) u_line.send_just(k == 0, 1'b0);
      repeat (2) u_line.send_just(k == 0, 1'b1);
      reg_write(hi, 8'h00);
      rd_chk(lo, 8'h2c);
      rd_chk(hi, 8'h01);
      u_line.send_just(k == 0, 1'b0);
      rd_chk(lo, 8'h2c);
      reg_write(hi, 8'h5a);
      rd_chk(lo, 8'h01);
      rd_chk(hi, 8'h00);
      reg_write(8'h51, 8'h08);
      repeat (2) u_line.send_just(k == 0, 1'b1);
      reg_write(hi, 8'h00);
      rd_chk(lo, 8'h02);
    end
    // Remote defect persistence, three frames then five.
    repeat (2) u_line.send_frame(3'h4);
    settle();
    check(16'(path_remote_defect_status), 16'h0000);
    u_line.send_frame(3'h4);
    settle();
    check(16'(path_remote_defect_status), 16'h0001);
    rd_chk(8'h85, 8'h04);
    reg_write(8'h80, 8'h80);
    repeat (4) u_line.send_frame(3'h0);
    settle();
    check(16'(path_remote_defect_status), 16'h0001);
    u_line.send_frame(3'h0);
    settle();
    check(16'(path_remote_defect_status), 16'h0000);
    // Label mismatch persistence, three then five.
    reg_write(8'h80, 8'h00);
    reg_write(8'h82, 8'h13);
    repeat (2) u_line.send_label(8'h99);
    settle();
    check(16'(label_mismatch_status), 16'h0000);
    u_line.send_label(8'h99);
    settle();
    check(16'(label_mismatch_status), 16'h0001);
    rd_chk(8'h83, 8'h99);
    rd_chk(8'hc5, 8'h10);
    reg_write(8'h80, 8'h40);
    repeat (4) u_line.send_label(8'h13);
    settle();
    check(16'(label_mismatch_status), 16'h0001);
    u_line.send_label(8'h13);
    settle();
    check(16'(label_mismatch_status), 16'h0000);
    finish_test();
  end
endmodule : tb_top
